// *** hw/wamu_pkg.sv ***
// Package for the word arithmetic and multiply unit: operand forms,
// request and flag carriers, instruction lengths and clock counts.
// Assumes a single CPU clock domain.
package wamu_pkg;

  localparam int WORD_W = 16;
  localparam int BYTE_W = 8;
  localparam int SEG_W = 4;
  localparam int PADDR_W = SEG_W + WORD_W;
  localparam int CNT_W = 4;

  typedef enum logic [1:0] {
    op_word_add,
    op_word_subtract,
    op_word_compare,
    op_unsigned_multiply
  } wamu_op_t;

  // Memory forms sit at and above src_saddr
  typedef enum logic [3:0] {
    src_imm,
    src_acc,
    src_bc,
    src_de,
    src_hl,
    src_saddr,
    src_abs,
    src_hl_disp,
    src_es_abs,
    src_es_hl_disp
  } wamu_src_t;

  typedef struct packed {
    logic valid;
    wamu_op_t op;
    wamu_src_t src;
    logic [WORD_W-1:0] imm;
    logic [BYTE_W-1:0] disp;
    logic [WORD_W-1:0] addr;
    logic [SEG_W-1:0] seg;
    logic from_ram;
  } wamu_req_t;

  typedef struct packed {
    logic z;
    logic ac;
    logic cy;
  } wamu_flags_t;

  localparam logic [WORD_W-1:0] ACC_RST = 16'h0000;
  localparam wamu_flags_t FLAGS_RST = 3'h0;

  localparam logic [2:0] LEN_REG = 3'h1;
  localparam logic [2:0] LEN_SADDR = 3'h2;
  localparam logic [2:0] LEN_WORD = 3'h3;
  localparam logic [2:0] LEN_ES = 3'h4;

  localparam logic [CNT_W-1:0] CLK_BASE = 4'h1;
  localparam logic [CNT_W-1:0] CLK_PROG = 4'h4;
  localparam logic [CNT_W-1:0] CLK_ES = 4'h2;
  localparam logic [CNT_W-1:0] CLK_ES_PROG = 4'h5;
  localparam logic [CNT_W-1:0] CLK_RAM_ADD = 4'h3;

endpackage : wamu_pkg

// *** hw/wamu_unit.sv ***
// Word add, subtract, compare and 8x8 unsigned multiply unit.
// Assumes the sequencer holds BC, DE, HL and X stable while a request is
// taken, and that memory answers combinationally while mem_rd is high.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [RULE_01] Word add writes 16-bit sum to accumulator pair, carry out to carry flag.
// [RULE_02] Word add operand: immediate, accumulator pair, BC, DE or HL; register forms one byte.
// [RULE_03] Word subtract stores difference in accumulator pair, borrow in carry flag.
// [RULE_04] Subtract and compare never take the accumulator pair as operand.
// [RULE_05] Word compare only updates flags; accumulator pair stays unchanged.
// [RULE_06] Multiply A by X into accumulator pair; one byte, one clock, no flags.
// [RULE_07] Short direct operand uses one-byte offset, two bytes, one clock.
// [RULE_08] Indexed address is HL plus 8-bit displacement; three bytes, one clock.
// [RULE_09] Segment forms prefix the segment register; four bytes, two clocks or five.
// [RULE_10] Unsegmented absolute or indexed forms take four clocks in program memory.
// [RULE_11] Each instruction clock is one CPU clock period.
// [RULE_12] Fetching from internal RAM costs twice the count plus three clocks.
// [RULE_13] Word add accepts an absolute 16-bit address, three bytes long.
// [RULE_14] Zero flag on zero result; aux carry is carry or borrow from bit 3.
// [RULE_15] Segment value sits above the 16-bit address to form the physical address.
module wamu_unit
  import wamu_pkg::*;
#(
  parameter logic [WORD_W-1:0] SADDR_BASE = 16'hFE20,
  parameter logic [SEG_W-1:0] DEF_SEG = 4'hF,
  parameter logic [PADDR_W-1:0] PROG_END = 20'h0FFFF,
  parameter logic [WORD_W-1:0] MIRROR_END = 16'h8000
) (
  input wire logic clock,
  input wire logic resetn,
  input wire wamu_req_t req,
  input wire logic [WORD_W-1:0] pair_bc,
  input wire logic [WORD_W-1:0] pair_de,
  input wire logic [WORD_W-1:0] pair_hl,
  input wire logic [BYTE_W-1:0] reg_x,
  input wire logic acc_load,
  input wire logic [WORD_W-1:0] acc_load_value,
  input wire logic [WORD_W-1:0] mem_rdata,
  output logic req_ready,
  output logic req_refused,
  output logic mem_rd,
  output logic [PADDR_W-1:0] mem_addr,
  output logic done,
  output logic [2:0] instr_len,
  output logic [CNT_W-1:0] instr_clocks,
  output logic [WORD_W-1:0] accumulator_pair,
  output wamu_flags_t flags
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Returns {carry or borrow, nibble carry or borrow, result}
  function automatic logic [WORD_W+1:0] word_arith(input logic sub,
                                                   input logic [WORD_W-1:0] a,
                                                   input logic [WORD_W-1:0] b);
    logic [WORD_W:0] full;
    logic [4:0] nib;
    full = sub ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    nib = sub ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
    return {full[WORD_W], nib[4], full[WORD_W-1:0]};
  endfunction : word_arith

  function automatic logic [2:0] len_of(input wamu_op_t op, input wamu_src_t src);
    logic [2:0] len;
    len = LEN_REG;
    if (op != op_unsigned_multiply) begin
      case (src)
        src_imm, src_abs, src_hl_disp: len = LEN_WORD;
        src_saddr: len = LEN_SADDR;
        src_es_abs, src_es_hl_disp: len = LEN_ES;
        default: len = LEN_REG;
      endcase
    end
    return len;
  endfunction : len_of

  ////////////////////////////////////////////////////////////////////////
  // Request decode

  typedef enum logic {st_idle, st_exec} wamu_state_t;

  wamu_state_t state;
  logic [CNT_W-1:0] count;
  wamu_op_t op_q;
  logic mem_q;
  logic [WORD_W-1:0] opnd_q;

  wire is_mul = req.op == op_unsigned_multiply;
  wire is_es = !is_mul && (req.src == src_es_abs || req.src == src_es_hl_disp);
  wire is_mem = !is_mul && req.src >= src_saddr;
  // Only the add form may fold the accumulator pair onto itself
  wire illegal = !is_mul && req.op != op_word_add && req.src == src_acc; // RULE_04
  wire [WORD_W-1:0] hl_sum = pair_hl + {8'h00, req.disp}; // RULE_08
  wire [WORD_W-1:0] saddr_sum = SADDR_BASE + {8'h00, req.disp}; // RULE_07
  wire use_hl = req.src == src_hl_disp || req.src == src_es_hl_disp;
  wire [WORD_W-1:0] addr16 = req.src == src_saddr ? saddr_sum :
                             use_hl ? hl_sum : req.addr; // RULE_13
  wire [PADDR_W-1:0] phys = {is_es ? req.seg : DEF_SEG, addr16}; // RULE_15
  // Short direct space never maps onto program memory
  wire prog_hit = is_es ? phys <= PROG_END :
                  (req.src == src_abs || req.src == src_hl_disp) && addr16 < MIRROR_END;
  wire [CNT_W-1:0] base_clk = is_es ? (prog_hit ? CLK_ES_PROG : CLK_ES) : // RULE_09
                              is_mem && prog_hit ? CLK_PROG : CLK_BASE; // RULE_10
  // Charge the worst case for RAM fetch so the count is deterministic
  wire [CNT_W-1:0] total_clk = req.from_ram ? CNT_W'(base_clk * 2) + CLK_RAM_ADD : base_clk; // RULE_12
  wire [WORD_W-1:0] reg_opnd = is_mul ? {8'h00, reg_x} :
                               req.src == src_acc ? accumulator_pair :
                               req.src == src_bc ? pair_bc :
                               req.src == src_de ? pair_de :
                               req.src == src_hl ? pair_hl : req.imm; // RULE_02

  assign req_ready = state == st_idle;
  assign req_refused = req.valid && req_ready && illegal; // RULE_04
  wire accept = req.valid && req_ready && !illegal;

  ////////////////////////////////////////////////////////////////////////
  // Execution

  wire finish = state == st_exec && count == CLK_BASE; // RULE_11
  wire [WORD_W-1:0] operand = mem_q ? mem_rdata : opnd_q;
  wire [WORD_W+1:0] arith = word_arith(op_q != op_word_add, accumulator_pair, operand);
  wire [WORD_W-1:0] product = {8'h00, accumulator_pair[15:8]} * {8'h00, opnd_q[7:0]}; // RULE_06
  wire acc_write = finish && op_q != op_word_compare; // RULE_05
  wire flag_write = finish && op_q != op_unsigned_multiply; // RULE_06

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= st_idle;
      count <= '0;
    end else if (accept) begin
      state <= st_exec;
      count <= total_clk;
    end else if (finish) begin
      state <= st_idle;
    end else if (state == st_exec) begin
      count <= count - CLK_BASE;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      op_q <= op_word_add;
      mem_q <= 1'b0;
      opnd_q <= '0;
      instr_len <= '0;
      instr_clocks <= '0;
      mem_addr <= '0;
    end else if (accept) begin
      op_q <= req.op;
      mem_q <= is_mem;
      opnd_q <= reg_opnd;
      instr_len <= len_of(req.op, req.src);
      instr_clocks <= total_clk;
      mem_addr <= phys; // RULE_08 RULE_15
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      mem_rd <= 1'b0;
      done <= 1'b0;
    end else begin
      mem_rd <= accept ? is_mem : mem_rd && !finish;
      done <= finish;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      accumulator_pair <= ACC_RST;
    end else if (acc_write) begin
      accumulator_pair <= op_q == op_unsigned_multiply ? product : arith[WORD_W-1:0]; // RULE_01 RULE_03
    end else if (acc_load && req_ready) begin
      accumulator_pair <= acc_load_value;
    end
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      flags <= FLAGS_RST;
    end else if (flag_write) begin
      flags.z <= arith[WORD_W-1:0] == 16'h0000; // RULE_14
      flags.ac <= arith[WORD_W]; // RULE_14
      flags.cy <= arith[WORD_W+1]; // RULE_01 RULE_03
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Assertions

  add_sum_carry_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_01
    finish && op_q == op_word_add |=>
      {flags.cy, accumulator_pair} == $past({1'b0, accumulator_pair} + {1'b0, operand}))
    else $error("word add sum or carry wrong");

  sub_diff_borrow_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_03
    finish && op_q == op_word_subtract |=>
      {flags.cy, accumulator_pair} == $past({1'b0, accumulator_pair} - {1'b0, operand}))
    else $error("word subtract difference or borrow wrong");

  acc_form_refused_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_04
    req.valid && req_ready && req.src == src_acc &&
    (req.op == op_word_subtract || req.op == op_word_compare) |-> req_refused ##1 req_ready)
    else $error("accumulator operand not refused");

  cmp_keeps_acc_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_05
    finish && op_q == op_word_compare |=> $stable(accumulator_pair))
    else $error("compare altered accumulator pair");

  mul_one_clock_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
    accept && is_mul && !req.from_ram |-> ##2 done &&
      accumulator_pair == {8'h00, $past(accumulator_pair[15:8])} * {8'h00, $past(reg_x, 2)} &&
      $stable(flags))
    else $error("multiply result or timing wrong");

  saddr_timing_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_07 RULE_11
    accept && !is_mul && req.src == src_saddr && !req.from_ram |=>
      !done && instr_len == LEN_SADDR ##1 done)
    else $error("short direct form timing or length wrong");

  hl_index_addr_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
    accept && !is_mul && req.src == src_hl_disp |=>
      mem_rd && mem_addr[15:0] == $past(pair_hl + {8'h00, req.disp}))
    else $error("indexed address wrong");

  seg_prefix_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_09 RULE_15
    accept && is_es |=> mem_addr[19:16] == $past(req.seg) && instr_len == LEN_ES)
    else $error("segment prefix or length wrong");

  prog_four_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_10
    accept && !is_es && is_mem && prog_hit && !req.from_ram |-> ##4 !done ##1 done)
    else $error("program memory form not four clocks");

  ram_fetch_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_12
    accept && is_es && !prog_hit && req.from_ram |-> ##7 !done ##1 done)
    else $error("RAM fetch clock count wrong");

  word_len_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_02 RULE_13
    accept && !is_mul && (req.src == src_bc || req.src == src_abs) |=>
      instr_len == ($past(req.src) == src_bc ? LEN_REG : LEN_WORD))
    else $error("instruction length wrong");

  zero_aux_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_14
    flag_write |=> flags.z == ($past(arith[WORD_W-1:0]) == 16'h0000) &&
      flags.ac == ($past(operand[3:0]) > ($past(op_q) == op_word_add ?
      4'hF - $past(accumulator_pair[3:0]) : $past(accumulator_pair[3:0]))))
    else $error("zero or aux carry flag wrong");

  refused_no_latch_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_04
    req_refused |=> req_ready && !done && !mem_rd)
    else $error("refused request started execution");

  busy_not_ready_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_11
    accept |=> !req_ready)
    else $error("ready while executing");

  ready_at_done_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_11
    done |-> req_ready ##1 !done)
    else $error("done not a single cycle with ready");

  finish_done_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_10
    finish |=> done && !mem_rd)
    else $error("read strobe not dropped at done");

  read_hold_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_08
    mem_rd && !finish |=> mem_rd && $stable(mem_addr))
    else $error("operand read not held");

  flags_hold_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_06
    !flag_write |=> $stable(flags))
    else $error("flags changed without an update");

  acc_hold_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_05
    !acc_write && !(acc_load && req_ready) |=> $stable(accumulator_pair))
    else $error("accumulator pair changed without a write");

  cmp_borrow_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_05
    finish && op_q == op_word_compare |=> flags.cy == $past(accumulator_pair < operand))
    else $error("compare borrow wrong");

  abs_one_clock_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_13
    accept && !is_mul && req.src == src_abs && !prog_hit && !req.from_ram |=> !done ##1 done)
    else $error("absolute form outside program memory not one clock");

  es_prog_five_a: assert property (@(posedge clock) disable iff (!resetn) // RULE_09
    accept && is_es && prog_hit && !req.from_ram |-> ##5 !done ##1 done)
    else $error("segment form in program memory not five clocks");

  add_seen_c: cover property (@(posedge clock) disable iff (!resetn)
    accept && req.op == op_word_add && req.src == src_imm);
  es_prog_c: cover property (@(posedge clock) disable iff (!resetn)
    accept && is_es && prog_hit);
  refused_c: cover property (@(posedge clock) disable iff (!resetn) req_refused);
  mul_seen_c: cover property (@(posedge clock) disable iff (!resetn) accept && is_mul);
  ram_fetch_c: cover property (@(posedge clock) disable iff (!resetn)
    accept && is_mem && req.from_ram);

endmodule : wamu_unit

`default_nettype wire

// *** tb/wamu_mem_model.sv ***
// Operand memory on the far side of the unit's read port.
// Assumes reads are answered combinationally while mem_rd is high.
`timescale 1ns/1ps
`default_nettype none
module wamu_mem_model
  import wamu_pkg::*;
(
  input wire logic clock,
  input wire logic mem_rd,
  input wire logic [PADDR_W-1:0] mem_addr,
  output logic [WORD_W-1:0] mem_rdata
);
  logic [WORD_W-1:0] idle_pat = 16'h3C96;
  // Flips every cycle so a read outside mem_rd never looks valid
  always_ff @(posedge clock) begin
    idle_pat <= ~idle_pat;
  end
  // Word depends on all 20 address bits, so a wrong segment shows
  assign mem_rdata = mem_rd ? (mem_addr[15:0] ^ {mem_addr[19:16], 12'hA53}) : idle_pat;
endmodule : wamu_mem_model
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the word arithmetic and multiply unit.
// Assumes the memory model answers operand reads.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import wamu_pkg::*;
  logic clock, resetn, acc_load, req_ready, req_refused, mem_rd, done;
  wamu_req_t req;
  logic [WORD_W-1:0] pair_bc, pair_de, pair_hl, acc_load_value, mem_rdata, accumulator_pair;
  logic [BYTE_W-1:0] reg_x;
  logic [PADDR_W-1:0] mem_addr;
  logic [2:0] instr_len;
  logic [CNT_W-1:0] instr_clocks;
  wamu_flags_t flags, flg_m;
  logic [15:0] acc_m;
  int fails = 0;
  int n_tests = 0;
  wamu_unit wamu_unit_inst (.clock(clock), .resetn(resetn), .req(req), .pair_bc(pair_bc),
    .pair_de(pair_de), .pair_hl(pair_hl), .reg_x(reg_x), .acc_load(acc_load),
    .acc_load_value(acc_load_value), .mem_rdata(mem_rdata), .req_ready(req_ready),
    .req_refused(req_refused), .mem_rd(mem_rd), .mem_addr(mem_addr), .done(done),
    .instr_len(instr_len), .instr_clocks(instr_clocks),
    .accumulator_pair(accumulator_pair), .flags(flags));
  wamu_mem_model wamu_mem_model_inst (.clock(clock), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (fails == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp_val
  task automatic cmp_flags(input wamu_flags_t got, input wamu_flags_t exp);
    cmp_val(20'(got), 20'(exp), "flags");
  endtask : cmp_flags
  task automatic check_reset();
    cmp_val(20'(accumulator_pair), 20'h0, "rst acc");
    cmp_flags(flags, '0);
    cmp_val(20'(req_ready), 20'h1, "rst ready");
    cmp_val(20'(done), 20'h0, "rst done");
    cmp_val(20'(mem_rd), 20'h0, "rst mem_rd");
  endtask : check_reset
  function automatic logic [19:0] exp_addr(wamu_req_t r);
    logic [15:0] hd;
    hd = pair_hl + 16'(r.disp);
    case (r.src)
      src_saddr: return {4'hF, 16'hFE20 + 16'(r.disp)};
      src_abs: return {4'hF, r.addr};
      src_hl_disp: return {4'hF, hd};
      src_es_abs: return {r.seg, r.addr};
      default: return {r.seg, hd};
    endcase
  endfunction : exp_addr
  function automatic logic [2:0] exp_len(wamu_req_t r);
    if (r.op == op_unsigned_multiply) return 3'h1;
    case (r.src)
      src_imm, src_abs, src_hl_disp: return 3'h3;
      src_saddr: return 3'h2;
      src_es_abs, src_es_hl_disp: return 3'h4;
      default: return 3'h1;
    endcase
  endfunction : exp_len
  function automatic logic [3:0] exp_clk(wamu_req_t r);
    logic [3:0] n;
    logic [19:0] a;
    a = exp_addr(r);
    n = 4'h1;
    if (r.op != op_unsigned_multiply && r.src inside {src_abs, src_hl_disp} && a[15:0] < 16'h8000)
      n = 4'h4;
    if (r.op != op_unsigned_multiply && r.src inside {src_es_abs, src_es_hl_disp})
      n = (a <= 20'h0FFFF) ? 4'h5 : 4'h2;
    return r.from_ram ? 4'(2 * n + 3) : n;
  endfunction : exp_clk
  ////////////////////////////////////////////////////////////////////////////
  task automatic run(input wamu_req_t r);
    logic [15:0] b, res;
    logic [19:0] a;
    logic mem;
    int k;
    r.valid = 1'b1;
    @(posedge clock);
    req <= r;
    a = exp_addr(r);
    mem = r.op != op_unsigned_multiply && r.src >= src_saddr;
    case (r.src)
      src_imm: b = r.imm;
      src_acc: b = acc_m;
      src_bc: b = pair_bc;
      src_de: b = pair_de;
      src_hl: b = pair_hl;
      default: b = a[15:0] ^ {a[19:16], 12'hA53};
    endcase
    if (r.op == op_word_add) begin
      res = acc_m + b;
      flg_m = {res == 16'h0000, (5'(acc_m[3:0]) + 5'(b[3:0])) > 5'h0F, (17'(acc_m) + 17'(b)) > 17'hFFFF};
    end else if (r.op == op_unsigned_multiply) begin
      res = 16'(acc_m[15:8]) * 16'(reg_x);
    end else begin
      res = acc_m - b;
      flg_m = {res == 16'h0000, acc_m[3:0] < b[3:0], acc_m < b};
    end
    if (r.op != op_word_compare) acc_m = res;
    #1;
    cmp_val(20'(req_refused), 20'h0, "refused legal");
    @(posedge clock);
    req.valid <= 1'b0;
    #1;
    cmp_val(20'(req_ready), 20'h0, "busy");
    cmp_val(20'(mem_rd), 20'(mem), "mem_rd");
    if (mem) begin
      cmp_val(mem_addr, a, "mem_addr");
    end
    for (k = 1; k <= 40; k++) begin
      @(posedge clock);
      #1;
      if (done === 1'b1) break;
    end
    if (k > 40) begin
      fails++;
      conclude();
    end else begin
      cmp_val(20'(k), 20'(exp_clk(r)), "cycles");
      cmp_val(20'(instr_clocks), 20'(exp_clk(r)), "clocks");
      cmp_val(20'(instr_len), 20'(exp_len(r)), "len");
      cmp_val(20'(accumulator_pair), 20'(acc_m), "acc");
      cmp_flags(flags, flg_m);
      cmp_val(20'(req_ready), 20'h1, "ready at done");
      @(posedge clock);
      #1;
      cmp_val(20'(done), 20'h0, "done pulse");
    end
  endtask : run
  task automatic load(input logic [15:0] v);
    @(posedge clock);
    acc_load <= 1'b1;
    acc_load_value <= v;
    @(posedge clock);
    acc_load <= 1'b0;
    acc_m = v;
  endtask : load
  task automatic go(input wamu_op_t o, input wamu_src_t s, input logic [15:0] v,
                    input logic [3:0] sg, input logic ram);
    wamu_req_t r;
    r = '0;
    r.op = o;
    r.src = s;
    r.imm = v;
    r.addr = v;
    r.disp = 8'h10;
    r.seg = sg;
    r.from_ram = ram;
    run(r);
  endtask : go
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wamu_req_t r;
    req = '0;
    resetn = 1'b0;
    acc_load = 1'b0;
    acc_load_value = 16'h0000;
    {pair_bc, pair_de, pair_hl, reg_x} = '0;
    acc_m = 16'h0000;
    flg_m = '0;
    void'($urandom(32'h5e384df0));
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    #1;
    check_reset();
    load(16'hFFFF);
    go(op_word_add, src_imm, 16'h0001, 4'h0, 1'b0);
    pair_bc <= 16'h0001;
    go(op_word_subtract, src_bc, 16'h0, 4'h0, 1'b0);
    pair_de <= 16'hFFFF;
    go(op_word_compare, src_de, 16'h0, 4'h0, 1'b0);
    reg_x <= 8'hFF;
    go(op_unsigned_multiply, src_imm, 16'h0, 4'h0, 1'b0);
    pair_hl <= 16'h7FF0;
    go(op_word_add, src_hl_disp, 16'h0, 4'h0, 1'b0);
    go(op_word_add, src_es_abs, 16'hFFFF, 4'h0, 1'b1);
    go(op_word_add, src_es_abs, 16'h0000, 4'h1, 1'b0);
    @(posedge clock);
    r = '0;
    r.valid = 1'b1;
    r.src = src_acc;
    for (int o = 1; o < 3; o++) begin
      r.op = wamu_op_t'(o);
      req <= r;
      #1;
      cmp_val(20'(req_refused), 20'h1, "refused");
      @(posedge clock);
    end
    req.valid <= 1'b0;
    repeat (3) @(posedge clock);
    #1;
    cmp_val(20'(accumulator_pair), 20'(acc_m), "acc refused");
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    #1;
    check_reset();
    acc_m = 16'h0000;
    flg_m = '0;
    repeat (6) for (int o = 0; o < 4; o++) for (int s = 0; s < 10; s++) begin
      if (o != 0 && o != 3 && s == 1) continue;
      @(posedge clock);
      {pair_bc, pair_de} <= {$urandom, $urandom};
      {pair_hl, reg_x} <= 24'($urandom);
      r = wamu_req_t'(52'({$urandom, $urandom}));
      r.op = wamu_op_t'(o);
      r.src = wamu_src_t'(s);
      r.from_ram = ($urandom_range(0, 5) == 0);
      if ($urandom_range(0, 3) == 0) r.seg = 4'h0;
      run(r);
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
